// ---- core/nvm_ctrl_pkg.sv ----
package nvm_ctrl_pkg;

  // Register offsets of the control-port map
  localparam logic [11:0] OFF_TRANSFER_BUSY = 12'h0B00;
  localparam logic [11:0] OFF_DATA_ERROR = 12'h0B01;
  localparam logic [11:0] OFF_RELOAD_UNLOCK = 12'h0B02;
  localparam logic [11:0] OFF_SAVE_TRIGGER = 12'h0B03;
  localparam logic [11:0] OFF_UPDATE_STROBE = 12'h0232;
  localparam logic [11:0] OFF_STATUS_SEL = 12'h001D;

  // Field positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_ERROR = 0;
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_SAVE = 0;
  localparam int BIT_UPDATE = 0;
  localparam int BIT_STATUS_SEL = 7;
  localparam int BIT_OPCODE = 7;

  // Values after reset
  localparam logic RST_UNLOCK = 1'b0;
  localparam logic [7:0] RST_STATUS_SEL = 8'h00;

  // Buffer segment command encoding
  localparam logic [11:0] SEG_BASE = 12'h0A00;
  localparam logic [7:0] OP_APPLY = 8'h80;
  localparam logic [7:0] OP_END = 8'hFF;

  // Settle time between transfers, in ns, and in clock cycles at 8 ns
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR_HI, ST_ADDR_LO, ST_DATA, ST_DONE
  } seq_state_e;

  typedef enum logic {DIR_SAVE, DIR_LOAD} dir_e;

  // Register-access request from the serial control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Port to the buffer bank and nonvolatile array
  typedef struct packed {
    logic buf_rd;
    logic buf_wr;
    logic [11:0] buf_addr;
    logic [7:0] buf_wdata;
    logic nvm_rd;
    logic nvm_wr;
    logic [11:0] nvm_addr;
    logic [7:0] nvm_wdata;
  } mem_req_s;

endpackage

// ---- core/nvm_sync2.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for a level coming from a pin
module nvm_sync2 (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ---- core/nvm_config_save_load_control.sv ----
`timescale 1ns/1ps
module nvm_config_save_load_control (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire nvm_ctrl_pkg::reg_req_s req,
  output logic [7:0] rdata,
  input wire logic nvm_load_sel_pin,
  input wire logic [7:0] buf_rdata,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_parity_ok,
  output nvm_ctrl_pkg::mem_req_s mem,
  output logic apply_strobe,
  output logic soft_reset,
  output logic status_pin
);
  import nvm_ctrl_pkg::*;

  typedef struct packed {
    seq_state_e st;
    dir_e dir;
    logic busy;
    logic err;
    logic unlock;
    logic save_bit;
    logic [7:0] status_sel;
    logic [11:0] seg_ptr;
    logic [11:0] dst_addr;
    logic [11:0] nvm_ptr;
    logic [6:0] count;
    logic [13:0] settle;
    logic [7:0] rdata;
    logic apply;
    logic soft_rst;
    logic status_pin;
    logic rd_pend;
    mem_req_s mem;
  } state_s;

  state_s s_q, s_d;
  logic load_sel_sync;

  nvm_sync2 u_load_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .din(nvm_load_sel_pin),
    .dout(load_sel_sync)
  );

  // Next-state: register file, command sequencer and strobes
  always_comb begin
    logic [7:0] rd;
    logic [7:0] byte_in;
    rd = 8'h00;
    byte_in = (s_q.dir == DIR_SAVE) ? buf_rdata : nvm_rdata;
    s_d = s_q;
    s_d.apply = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.mem = '0;
    if (s_q.settle != '0) begin
      s_d.settle = s_q.settle - 14'd1;
    end

    // Register reads; unused bits read zero
    if (req.addr == OFF_TRANSFER_BUSY) begin
      rd[BIT_BUSY] = s_q.busy;
    end else if (req.addr == OFF_DATA_ERROR) begin
      rd[BIT_ERROR] = s_q.err;
    end else if (req.addr == OFF_RELOAD_UNLOCK) begin
      rd[BIT_UNLOCK] = s_q.unlock;
    end else if (req.addr == OFF_SAVE_TRIGGER) begin
      rd[BIT_SAVE] = s_q.save_bit;
    end else if (req.addr == OFF_STATUS_SEL) begin
      rd = s_q.status_sel;
    end
    if (req.rd) begin
      s_d.rdata = rd;
    end

    // Register writes
    if (req.wr) begin
      if (req.addr == OFF_RELOAD_UNLOCK) begin
        s_d.unlock = req.wdata[BIT_UNLOCK];
        // Reload only from idle, and only when the pin selects storage
        if (req.wdata[BIT_RELOAD] && !load_sel_sync &&
            s_q.st == ST_IDLE) begin
          s_d.soft_rst = 1'b1;
          s_d.st = ST_CMD;
          s_d.dir = DIR_LOAD;
          s_d.busy = 1'b1;
          s_d.err = 1'b0;
          s_d.seg_ptr = SEG_BASE;
          s_d.nvm_ptr = '0;
        end
      end else if (req.addr == OFF_SAVE_TRIGGER) begin
        // Locked or already running: request dropped, busy untouched
        if (req.wdata[BIT_SAVE] && s_q.unlock &&
            s_q.st == ST_IDLE) begin
          s_d.save_bit = 1'b1;
          s_d.st = ST_CMD;
          s_d.dir = DIR_SAVE;
          s_d.busy = 1'b1;
          s_d.err = 1'b0;
          s_d.seg_ptr = SEG_BASE;
          s_d.nvm_ptr = '0;
        end
      end else if (req.addr == OFF_UPDATE_STROBE) begin
        s_d.apply = req.wdata[BIT_UPDATE];
      end else if (req.addr == OFF_STATUS_SEL) begin
        s_d.status_sel = req.wdata;
      end
    end

    // Sequencer: each step issues a read, data returns next cycle
    case (s_q.st)
      ST_IDLE: begin
        s_d.rd_pend = 1'b0;
      end
      ST_CMD: begin
        if (!s_q.rd_pend) begin
          s_d.mem.nvm_rd = (s_q.dir == DIR_LOAD);
          s_d.mem.nvm_addr = s_q.nvm_ptr;
          s_d.mem.buf_rd = (s_q.dir == DIR_SAVE);
          s_d.mem.buf_addr = s_q.seg_ptr;
          s_d.rd_pend = 1'b1;
        end else begin
          s_d.rd_pend = 1'b0;
          if (s_q.dir == DIR_SAVE) begin
            s_d.mem.nvm_wr = s_q.unlock;
            s_d.mem.nvm_addr = s_q.nvm_ptr;
            s_d.mem.nvm_wdata = byte_in;
          end
          s_d.nvm_ptr = s_q.nvm_ptr + 12'd1;
          s_d.seg_ptr = s_q.seg_ptr + 12'd1;
          if (!byte_in[BIT_OPCODE]) begin
            s_d.count = byte_in[6:0];
            s_d.st = ST_ADDR_HI;
          end else if (byte_in == OP_END) begin
            s_d.st = ST_DONE;
          end else if (byte_in == OP_APPLY) begin
            s_d.apply = 1'b1;
          end else begin
            s_d.err = 1'b1;
            s_d.st = ST_DONE;
          end
          // Walking off the segment means no end code was present
          if (s_q.seg_ptr[7:0] == 8'hFF && byte_in != OP_END) begin
            s_d.err = 1'b1;
            s_d.st = ST_DONE;
          end
        end
      end
      ST_ADDR_HI, ST_ADDR_LO, ST_DATA: begin
        if (!s_q.rd_pend) begin
          s_d.mem.nvm_rd = (s_q.dir == DIR_LOAD) || (s_q.st == ST_DATA &&
            s_q.dir == DIR_LOAD);
          s_d.mem.nvm_addr = s_q.nvm_ptr;
          s_d.mem.buf_rd = (s_q.dir == DIR_SAVE);
          s_d.mem.buf_addr = (s_q.st == ST_DATA) ? s_q.dst_addr : s_q.seg_ptr;
          s_d.rd_pend = 1'b1;
        end else begin
          s_d.rd_pend = 1'b0;
          s_d.nvm_ptr = s_q.nvm_ptr + 12'd1;
          if (s_q.dir == DIR_SAVE) begin
            s_d.mem.nvm_wr = s_q.unlock;
            s_d.mem.nvm_addr = s_q.nvm_ptr;
            s_d.mem.nvm_wdata = byte_in;
          end else if (s_q.st == ST_DATA) begin
            s_d.mem.buf_wr = 1'b1;
            s_d.mem.buf_addr = s_q.dst_addr;
            s_d.mem.buf_wdata = byte_in;
            if (!nvm_parity_ok) begin
              s_d.err = 1'b1;
            end
          end
          if (s_q.st == ST_ADDR_HI) begin
            s_d.dst_addr[11:8] = byte_in[3:0];
            s_d.seg_ptr = s_q.seg_ptr + 12'd1;
            s_d.st = ST_ADDR_LO;
          end else if (s_q.st == ST_ADDR_LO) begin
            s_d.dst_addr[7:0] = byte_in;
            s_d.seg_ptr = s_q.seg_ptr + 12'd1;
            s_d.st = ST_DATA;
          end else begin
            s_d.dst_addr = s_q.dst_addr + 12'd1;
            s_d.count = s_q.count - 7'd1;
            if (s_q.count == '0) begin
              s_d.st = ST_CMD;
            end
          end
        end
      end
      default: begin
        // Finish: drop busy and the save bit together
        s_d.busy = 1'b0;
        s_d.save_bit = 1'b0;
        s_d.settle = 14'(SETTLE_CYC);
        s_d.st = ST_IDLE;
      end
    endcase

    s_d.status_pin = s_d.status_sel[BIT_STATUS_SEL] & s_d.busy;
  end

  // All state except the pin synchroniser in one register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{st: ST_IDLE, dir: DIR_SAVE, unlock: RST_UNLOCK,
               status_sel: RST_STATUS_SEL, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign mem = s_q.mem;
  assign apply_strobe = s_q.apply;
  assign soft_reset = s_q.soft_rst;
  assign status_pin = s_q.status_pin;

  a_locked_save: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.wr && req.addr == OFF_SAVE_TRIGGER && !s_q.unlock && !s_q.busy)
    |=> !s_q.busy) else $error("locked save started");
  a_no_locked_write: assert property (@(posedge sys_clk)
    disable iff (!reset_n) s_q.mem.nvm_wr |-> $past(s_q.unlock))
    else $error("storage written while locked");
  a_save_bit_busy: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.save_bit |-> s_q.busy) else $error("save bit without busy");
  a_status_pin: assert property (@(posedge sys_clk) disable iff (!reset_n)
    status_pin == (s_q.status_sel[BIT_STATUS_SEL] && s_q.busy))
    else $error("status pin mismatch");
  a_update_next: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.wr && req.addr == OFF_UPDATE_STROBE && req.wdata[BIT_UPDATE])
    |=> apply_strobe) else $error("update strobe late");
  a_update_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (apply_strobe && !(req.wr && req.addr == OFF_UPDATE_STROBE))
    ##0 (s_q.st == ST_IDLE) |=> !apply_strobe)
    else $error("update strobe stuck");
  a_reload_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    soft_reset |-> ##1 (!soft_reset && s_q.busy && s_q.dir == DIR_LOAD))
    else $error("reload not single pulse");
  a_save_starts: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.wr && req.addr == OFF_SAVE_TRIGGER && req.wdata[BIT_SAVE] &&
     s_q.unlock && s_q.st == ST_IDLE) |=> (s_q.busy && s_q.save_bit))
    else $error("save did not start");
  a_busy_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.rd && req.addr == OFF_TRANSFER_BUSY) |=>
    rdata[BIT_BUSY] == $past(s_q.busy)) else $error("busy read wrong");
endmodule

// ---- dv/nvm_mem_model.sv ----
`timescale 1ns/1ps
// Buffer bank and storage array as seen from the sequencer side
module nvm_mem_model
  import nvm_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire nvm_ctrl_pkg::mem_req_s mem,
  input wire logic bad_parity,
  output logic [7:0] buf_rdata,
  output logic [7:0] nvm_rdata,
  output logic nvm_parity_ok
);
  logic [7:0] buf_mem [4096];
  logic [7:0] nvm_mem [4096];
  // Reads answer in the cycle the strobe stands, which is when the
  // sequencer uses them; an idle port shows the inverse so stale bytes fail
  assign buf_rdata = mem.buf_rd ? buf_mem[mem.buf_addr] :
    ~buf_mem[mem.buf_addr];
  assign nvm_rdata = mem.nvm_rd ? nvm_mem[mem.nvm_addr] :
    ~nvm_mem[mem.nvm_addr];
  assign nvm_parity_ok = mem.nvm_rd ? !bad_parity : bad_parity;
  // Writes land at the end of the cycle in which the strobe stands
  always @(posedge sys_clk) begin
    if (mem.buf_wr) buf_mem[mem.buf_addr] <= mem.buf_wdata;
    if (mem.nvm_wr) nvm_mem[mem.nvm_addr] <= mem.nvm_wdata;
  end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import nvm_ctrl_pkg::*;
  logic sys_clk, reset_n, nvm_load_sel_pin, bad_parity, nvm_parity_ok;
  logic apply_strobe, soft_reset, status_pin;
  logic [7:0] rdata, buf_rdata, nvm_rdata, r;
  reg_req_s req;
  mem_req_s mem;
  int n_errors, samples_checked, n_wr, n_soft, n_apply;
  logic [7:0] stream [7] = '{8'h01, 8'h00, 8'h10, 8'h5A, 8'hC3,
    OP_APPLY, OP_END};

  nvm_config_save_load_control dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .req(req), .rdata(rdata), .nvm_load_sel_pin(nvm_load_sel_pin),
    .buf_rdata(buf_rdata), .nvm_rdata(nvm_rdata),
    .nvm_parity_ok(nvm_parity_ok), .mem(mem), .apply_strobe(apply_strobe),
    .soft_reset(soft_reset), .status_pin(status_pin));
  nvm_mem_model partner (.sys_clk(sys_clk), .mem(mem),
    .bad_parity(bad_parity), .buf_rdata(buf_rdata), .nvm_rdata(nvm_rdata),
    .nvm_parity_ok(nvm_parity_ok));

  // Free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Pulse counters, so short strobes are never missed between polls
  always @(posedge sys_clk) begin
    if (mem.nvm_wr === 1'b1) n_wr++;
    if (soft_reset === 1'b1) n_soft++;
    if (apply_strobe === 1'b1) n_apply++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask
  // Read data is registered, so sample it at the second falling edge after the take
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rd(OFF_TRANSFER_BUSY, r);
      if (r[BIT_BUSY] === 1'b0) break;
    end
    check(r, 8'h00);
  endtask
  // Storage needs quiet time after every transfer
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    logic [11:0] regs [6] = '{OFF_TRANSFER_BUSY, OFF_DATA_ERROR,
      OFF_RELOAD_UNLOCK, OFF_SAVE_TRIGGER, OFF_STATUS_SEL, 12'h0123};
    foreach (regs[i]) begin
      rd(regs[i], r);
      check(r, 8'h00);
    end
  endtask
  task automatic t_locked();
    wr(OFF_SAVE_TRIGGER, 8'h01);
    repeat (30) @(posedge sys_clk);
    check(8'(n_wr), 8'h00);
    rd(OFF_TRANSFER_BUSY, r);
    check(r, 8'h00);
  endtask
  task automatic t_update();
    int a0;
    a0 = n_apply;
    wr(OFF_UPDATE_STROBE, 8'h01);
    repeat (2) @(posedge sys_clk);
    check(8'(n_apply - a0), 8'h01);
  endtask
  task automatic t_save();
    foreach (stream[i]) begin
      if (i < 3) partner.buf_mem[SEG_BASE + i] = stream[i];
      else if (i < 5) partner.buf_mem[12'h00D + i] = stream[i];
      else partner.buf_mem[SEG_BASE + i - 2] = stream[i];
    end
    wr(OFF_STATUS_SEL, 8'h80);
    wr(OFF_RELOAD_UNLOCK, 8'h01);
    wr(OFF_SAVE_TRIGGER, 8'h01);
    check({7'h00, status_pin}, 8'h01);
    rd(OFF_SAVE_TRIGGER, r);
    check(r, 8'h01);
    wait_idle();
    rd(OFF_SAVE_TRIGGER, r);
    check(r, 8'h00);
    check({7'h00, status_pin}, 8'h00);
    check(8'(n_wr), 8'h07);
    foreach (stream[i]) check(partner.nvm_mem[i], stream[i]);
  endtask
  task automatic t_reload(input logic bad);
    int s0, a0;
    settle();
    partner.buf_mem[12'h010] = 8'h00;
    partner.buf_mem[12'h011] = 8'h00;
    @(negedge sys_clk);
    bad_parity = bad;
    s0 = n_soft;
    a0 = n_apply;
    wr(OFF_RELOAD_UNLOCK, 8'h03);
    wait_idle();
    check(8'(n_soft - s0), 8'h01);
    rd(OFF_RELOAD_UNLOCK, r);
    check({7'h00, r[BIT_RELOAD]}, 8'h00);
    rd(OFF_DATA_ERROR, r);
    check(r, {7'h00, bad});
    if (!bad) begin
      check(partner.buf_mem[12'h010], 8'h5A);
      check(partner.buf_mem[12'h011], 8'hC3);
      check(8'(n_apply - a0), 8'h01);
    end
  endtask
  task automatic t_pin_high();
    int s0;
    settle();
    @(negedge sys_clk);
    nvm_load_sel_pin = 1'b1;
    bad_parity = 1'b0;
    repeat (4) @(posedge sys_clk);
    s0 = n_soft;
    wr(OFF_RELOAD_UNLOCK, 8'h03);
    repeat (20) @(posedge sys_clk);
    check(8'(n_soft - s0), 8'h00);
    rd(OFF_TRANSFER_BUSY, r);
    check(r, 8'h00);
  endtask
  // An unknown operation code must stop the save and flag an error
  task automatic t_bad_op();
    partner.buf_mem[SEG_BASE] = 8'h81;
    wr(OFF_SAVE_TRIGGER, 8'h01);
    wait_idle();
    rd(OFF_DATA_ERROR, r);
    check(r, 8'h01);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    req = '0;
    nvm_load_sel_pin = 1'b0;
    bad_parity = 1'b0;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_locked();
    t_update();
    t_save();
    t_reload(1'b0);
    t_reload(1'b1);
    t_pin_high();
    t_bad_op();
    finish_test();
  end
endmodule
